/* File: slt_pkg.sv */
// package: register map, field widths, reset values and ranges of the servo tuning core
package slt_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] REG_TORQUE_FILTER_TIME = 8'h00;
    localparam logic [7:0] REG_NOTCH_ENABLE = 8'h04;
    localparam logic [7:0] REG_NOTCH_FREQ = 8'h08;
    localparam logic [7:0] REG_SPEED_GAIN = 8'h0C;
    localparam logic [7:0] REG_SPEED_INTEGRAL = 8'h10;
    localparam logic [7:0] REG_INERTIA_RATIO = 8'h14;
    localparam logic [7:0] REG_POSITION_GAIN = 8'h18;
    localparam logic [7:0] REG_OVERFLOW_LEVEL = 8'h1C;
    localparam logic [7:0] REG_FF_WEIGHT = 8'h20;
    localparam logic [7:0] REG_TUNE_CTRL = 8'h24;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h28;
    localparam logic [7:0] REG_IRQ_MASK = 8'h2C;
    localparam logic [7:0] REG_POS_ERROR = 8'h30;

    // ------------------------------------------------------------
    // reset values and legal ranges
    // ------------------------------------------------------------
    localparam logic [15:0] TFT_RST = 16'h0064;   // 100 x 0.01 ms
    localparam logic [15:0] TFT_MAX = 16'hFFFF;   // 65535
    localparam logic [15:0] NFQ_RST = 16'h07D0;   // 2000 Hz
    localparam logic [15:0] NFQ_MIN = 16'h0032;   // 50 Hz
    localparam logic [15:0] NFQ_MAX = 16'h07D0;   // 2000 Hz
    localparam logic [15:0] SPG_RST = 16'h0028;   // 40 Hz
    localparam logic [15:0] SPG_MIN = 16'h0001;
    localparam logic [15:0] SPG_MAX = 16'h07D0;
    localparam logic [15:0] SIT_RST = 16'h07D0;   // 2000 x 0.01 ms
    localparam logic [15:0] SIT_MIN = 16'h000F;   // 15
    localparam logic [15:0] SIT_MAX = 16'hC800;   // 51200
    localparam logic [15:0] INR_RST = 16'h0064;   // 100 %
    localparam logic [15:0] INR_MAX = 16'h2710;   // 10000 %
    localparam logic [15:0] PSG_RST = 16'h0028;   // 40 1/s
    localparam logic [15:0] PSG_MAX = 16'h07D0;
    localparam logic [15:0] OVL_RST = 16'h0400;   // 1024
    localparam logic [15:0] OVL_MIN = 16'h0001;
    localparam logic [15:0] OVL_MAX = 16'h7FFF;   // 32767
    localparam logic [15:0] FFW_RST = 16'h0000;
    localparam logic [15:0] FFW_MAX = 16'h0064;   // 100 %
    localparam int OVL_SHIFT = 8;                 // level counts 256 reference units

    // ------------------------------------------------------------
    // status bit positions
    // ------------------------------------------------------------
    localparam int IRQ_OVERFLOW = 0;
    localparam int IRQ_TUNE_DONE = 1;
    localparam int IRQ_REJECT = 2;
    localparam int IRQ_W = 3;

    // ------------------------------------------------------------
    // fixed-point timing: 200 MHz clock, loop update every 10 us
    // ------------------------------------------------------------
    localparam int CLK_HZ = 200_000_000;
    localparam int LOOP_PERIOD_NS = 10_000;
    localparam int LOOP_CYCLES = LOOP_PERIOD_NS / (1_000_000_000 / CLK_HZ);

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] torqueFilterTime;
        logic notchEnableSelect;
        logic [15:0] notchCentreFrequency;
        logic [15:0] speedLoopGain;
        logic [15:0] speedIntegralTime;
        logic [15:0] inertiaRatio;
        logic [15:0] positionLoopGain;
        logic [15:0] errorOverflowLevel;
        logic [15:0] feedForwardWeight;
    } slt_cfg_s;

    // gains written by auto-tuning
    typedef struct packed {
        logic [15:0] speedLoopGain;
        logic [15:0] speedIntegralTime;
        logic [15:0] inertiaRatio;
        logic [15:0] positionLoopGain;
    } slt_tune_s;

endpackage

/* File: slt_range_check.sv */
// file: range check of one tuning setting against its legal limits
`timescale 1ns/1ps

module slt_range_check #(
    parameter logic [15:0] MIN_VAL = 16'h0000,
    parameter logic [15:0] MAX_VAL = 16'hFFFF
) (
    // candidate value
    input wire logic [31:0] value,
    // result
    output logic inRange
);
    // upper half must be zero, lower half within limits
    assign inRange = (value[31:16] == 16'h0000) && (value[15:0] >= MIN_VAL)
        && (value[15:0] <= MAX_VAL);
endmodule

/* File: slt_servo_core.sv */
// file: servo tuning core with torque filter, notch, PI speed loop, P position loop
// ----------------------------------------------------------------------
// Summary of operation
// - low-pass torque reference, time 0..65535, reset 100
// - notch select 0 bypass, 1 filter, reset 0
// - notch centre 50..2000 Hz, reset 2000
// - speed gain 1..2000 Hz, reset 40
// - integral time 15..51200, reset 2000
// - inertia ratio 0..10000 % scales speed gain
// - position gain 0..2000, also for zero clamp
// - alarm when error exceeds level times 256
// - feed-forward weighted 0..100 %, reset 0
// - auto-tuning overwrites four gain settings
// ----------------------------------------------------------------------
`timescale 1ns/1ps

module slt_servo_core #(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // references from host
    input wire logic signed [DATA_W-1:0] posRef,
    input wire logic signed [DATA_W-1:0] posFeedback,
    input wire logic signed [DATA_W-1:0] speedFeedback,
    input wire logic zeroClamp,
    // auto-tuning result
    input wire logic tuneValid,
    input wire slt_pkg::slt_tune_s tuneGains,
    // loop outputs
    output logic signed [DATA_W-1:0] speedCmd,
    output logic signed [DATA_W-1:0] torqueCmd,
    output logic positionErrorOverflowAlarm,
    output logic irq
);
    initial begin
        if (DATA_W < 8 || DATA_W > 24) begin
            $error("DATA_W must lie between 8 and 24");
        end
    end

    localparam int ACC_W = 48;
    localparam logic [15:0] LOOP_CNT_MAX = 16'(slt_pkg::LOOP_CYCLES - 1);

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    slt_pkg::slt_cfg_s cfg_q; // tuning settings
    logic [slt_pkg::IRQ_W-1:0] irqStatus_q; // sticky events
    logic [slt_pkg::IRQ_W-1:0] irqMask_q; // interrupt mask
    logic [15:0] loopCnt_q; // loop update divider
    logic signed [ACC_W-1:0] integ_q; // speed integrator
    logic signed [ACC_W-1:0] tfilt_q; // low-pass torque state
    logic signed [ACC_W-1:0] notchLp_q; // notch band state
    logic signed [ACC_W-1:0] posErr_q; // latched position error
    logic signed [ACC_W-1:0] prevRef_q; // previous position reference
    logic alarm_q; // overflow alarm level
    logic signed [DATA_W-1:0] speedCmd_q;
    logic signed [DATA_W-1:0] torqueCmd_q;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    wire busWrite = psel && penable && pwrite;
    wire busRead = psel && penable && !pwrite;
    wire selTft = paddr == slt_pkg::REG_TORQUE_FILTER_TIME;
    wire selNen = paddr == slt_pkg::REG_NOTCH_ENABLE;
    wire selNfq = paddr == slt_pkg::REG_NOTCH_FREQ;
    wire selSpg = paddr == slt_pkg::REG_SPEED_GAIN;
    wire selSit = paddr == slt_pkg::REG_SPEED_INTEGRAL;
    wire selInr = paddr == slt_pkg::REG_INERTIA_RATIO;
    wire selPsg = paddr == slt_pkg::REG_POSITION_GAIN;
    wire selOvl = paddr == slt_pkg::REG_OVERFLOW_LEVEL;
    wire selFfw = paddr == slt_pkg::REG_FF_WEIGHT;
    wire selTun = paddr == slt_pkg::REG_TUNE_CTRL;
    wire selSts = paddr == slt_pkg::REG_IRQ_STATUS;
    wire selMsk = paddr == slt_pkg::REG_IRQ_MASK;
    wire selErr = paddr == slt_pkg::REG_POS_ERROR;
    wire mapped = selTft | selNen | selNfq | selSpg | selSit | selInr | selPsg | selOvl
        | selFfw | selTun | selSts | selMsk | selErr;

    // range checks, one instance per limited setting
    logic okTft, okNen, okNfq, okSpg, okSit, okInr, okPsg, okOvl, okFfw;
    slt_range_check #(.MIN_VAL(16'h0000), .MAX_VAL(slt_pkg::TFT_MAX)) uTft (
        .value(pwdata), .inRange(okTft));
    slt_range_check #(.MIN_VAL(16'h0000), .MAX_VAL(16'h0001)) uNen (
        .value(pwdata), .inRange(okNen));
    slt_range_check #(.MIN_VAL(slt_pkg::NFQ_MIN), .MAX_VAL(slt_pkg::NFQ_MAX)) uNfq (
        .value(pwdata), .inRange(okNfq));
    slt_range_check #(.MIN_VAL(slt_pkg::SPG_MIN), .MAX_VAL(slt_pkg::SPG_MAX)) uSpg (
        .value(pwdata), .inRange(okSpg));
    slt_range_check #(.MIN_VAL(slt_pkg::SIT_MIN), .MAX_VAL(slt_pkg::SIT_MAX)) uSit (
        .value(pwdata), .inRange(okSit));
    slt_range_check #(.MIN_VAL(16'h0000), .MAX_VAL(slt_pkg::INR_MAX)) uInr (
        .value(pwdata), .inRange(okInr));
    slt_range_check #(.MIN_VAL(16'h0000), .MAX_VAL(slt_pkg::PSG_MAX)) uPsg (
        .value(pwdata), .inRange(okPsg));
    slt_range_check #(.MIN_VAL(slt_pkg::OVL_MIN), .MAX_VAL(slt_pkg::OVL_MAX)) uOvl (
        .value(pwdata), .inRange(okOvl));
    slt_range_check #(.MIN_VAL(16'h0000), .MAX_VAL(slt_pkg::FFW_MAX)) uFfw (
        .value(pwdata), .inRange(okFfw));

    // a write to a limited setting that fails its check is refused
    wire writeBad = busWrite && ((selTft && !okTft) || (selNen && !okNen) || (selNfq && !okNfq)
        || (selSpg && !okSpg) || (selSit && !okSit) || (selInr && !okInr)
        || (selPsg && !okPsg) || (selOvl && !okOvl) || (selFfw && !okFfw));
    wire writeOk = busWrite && !writeBad;

    // tuning control: writing 1 to bit 0 applies the present tuneGains inputs
    wire tuneApply = tuneValid || (writeOk && selTun && pwdata[0]);

    // ------------------------------------------------------------
    // apb answer: zero wait states, error on unmapped or refused
    // ------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!mapped || writeBad);

    // read mux
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        case (1'b1)
            selTft: rdMux = {16'h0000, cfg_q.torqueFilterTime};
            selNen: rdMux = {31'h0000_0000, cfg_q.notchEnableSelect};
            selNfq: rdMux = {16'h0000, cfg_q.notchCentreFrequency};
            selSpg: rdMux = {16'h0000, cfg_q.speedLoopGain};
            selSit: rdMux = {16'h0000, cfg_q.speedIntegralTime};
            selInr: rdMux = {16'h0000, cfg_q.inertiaRatio};
            selPsg: rdMux = {16'h0000, cfg_q.positionLoopGain};
            selOvl: rdMux = {16'h0000, cfg_q.errorOverflowLevel};
            selFfw: rdMux = {16'h0000, cfg_q.feedForwardWeight};
            selSts: rdMux = {29'h0000_0000, irqStatus_q};
            selMsk: rdMux = {29'h0000_0000, irqMask_q};
            selErr: rdMux = posErr_q[31:0];
            default: rdMux = 32'h0000_0000;
        endcase
    end
    assign prdata = rdMux;

    // ------------------------------------------------------------
    // configuration write path
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q.torqueFilterTime <= slt_pkg::TFT_RST;
            cfg_q.notchEnableSelect <= 1'b0;
            cfg_q.notchCentreFrequency <= slt_pkg::NFQ_RST;
            cfg_q.speedLoopGain <= slt_pkg::SPG_RST;
            cfg_q.speedIntegralTime <= slt_pkg::SIT_RST;
            cfg_q.inertiaRatio <= slt_pkg::INR_RST;
            cfg_q.positionLoopGain <= slt_pkg::PSG_RST;
            cfg_q.errorOverflowLevel <= slt_pkg::OVL_RST;
            cfg_q.feedForwardWeight <= slt_pkg::FFW_RST;
            irqMask_q <= '0;
        end else begin
            if (writeOk && selTft) cfg_q.torqueFilterTime <= pwdata[15:0];
            if (writeOk && selNen) cfg_q.notchEnableSelect <= pwdata[0];
            if (writeOk && selNfq) cfg_q.notchCentreFrequency <= pwdata[15:0];
            if (writeOk && selOvl) cfg_q.errorOverflowLevel <= pwdata[15:0];
            if (writeOk && selFfw) cfg_q.feedForwardWeight <= pwdata[15:0];
            if (writeOk && selMsk) irqMask_q <= pwdata[slt_pkg::IRQ_W-1:0];
            // tuning result overwrites, taking priority over a bus write
            if (tuneApply) begin
                cfg_q.speedLoopGain <= tuneGains.speedLoopGain;
                cfg_q.speedIntegralTime <= tuneGains.speedIntegralTime;
                cfg_q.inertiaRatio <= tuneGains.inertiaRatio;
                cfg_q.positionLoopGain <= tuneGains.positionLoopGain;
            end else begin
                if (writeOk && selSpg) cfg_q.speedLoopGain <= pwdata[15:0];
                if (writeOk && selSit) cfg_q.speedIntegralTime <= pwdata[15:0];
                if (writeOk && selInr) cfg_q.inertiaRatio <= pwdata[15:0];
                if (writeOk && selPsg) cfg_q.positionLoopGain <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // loop tick: all filter and loop states update once per period
    // ------------------------------------------------------------
    wire tick = loopCnt_q == LOOP_CNT_MAX;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) loopCnt_q <= '0;
        else loopCnt_q <= tick ? 16'h0000 : loopCnt_q + 16'h0001;
    end

    // ------------------------------------------------------------
    // position loop arithmetic
    // ------------------------------------------------------------
    wire signed [ACC_W-1:0] refExt = ACC_W'(posRef);
    wire signed [ACC_W-1:0] errNow = refExt - ACC_W'(posFeedback);
    wire signed [ACC_W-1:0] refDelta = refExt - prevRef_q;
    // proportional term; the same gain holds at zero clamp, where reference is taken as zero
    wire signed [ACC_W-1:0] pTerm = errNow * $signed({1'b0, cfg_q.positionLoopGain});
    // feed-forward: reference change scaled by weight in percent
    wire signed [ACC_W-1:0] ffTerm =
        (refDelta * $signed({1'b0, cfg_q.feedForwardWeight})) / 100;
    // zero weight adds nothing at all
    wire signed [ACC_W-1:0] posOut = (cfg_q.feedForwardWeight == 16'h0000) ? pTerm
        : pTerm + ffTerm;
    wire signed [ACC_W-1:0] speedRef = zeroClamp ? (-ACC_W'(posFeedback)
        * $signed({1'b0, cfg_q.positionLoopGain})) : posOut;

    // overflow: magnitude against level times 256
    wire signed [ACC_W-1:0] errAbs = errNow < 0 ? -errNow : errNow;
    wire [ACC_W-1:0] ovlLimit = ACC_W'(cfg_q.errorOverflowLevel) << slt_pkg::OVL_SHIFT;
    wire overflowNow = $unsigned(errAbs) > ovlLimit;

    // ------------------------------------------------------------
    // speed loop: gain scaled by (100 + inertia) / 100, integral by time
    // ------------------------------------------------------------
    wire signed [ACC_W-1:0] spdErr = ACC_W'(speedCmd_q) - ACC_W'(speedFeedback);
    wire signed [ACC_W-1:0] kvEff =
        ($signed({1'b0, cfg_q.speedLoopGain}) * (100 + $signed({1'b0, cfg_q.inertiaRatio})))
        / 100;
    wire signed [ACC_W-1:0] kvTerm = spdErr * kvEff;
    // smaller integral time means larger step per tick
    wire signed [ACC_W-1:0] integStep = kvTerm / $signed({1'b0, cfg_q.speedIntegralTime});
    wire signed [ACC_W-1:0] piOut = kvTerm + integ_q;

    // ------------------------------------------------------------
    // torque filters: first-order low pass then optional notch
    // ------------------------------------------------------------
    wire signed [ACC_W-1:0] lpDen = $signed({1'b0, cfg_q.torqueFilterTime}) + 1;
    wire signed [ACC_W-1:0] lpNext = tfilt_q + (piOut - tfilt_q) / lpDen;
    // band tracker: coefficient grows with centre frequency
    wire signed [ACC_W-1:0] nDelta = ((lpNext - notchLp_q)
        * $signed({1'b0, cfg_q.notchCentreFrequency})) >>> 11;
    wire signed [ACC_W-1:0] notchOut = notchLp_q;
    wire signed [ACC_W-1:0] torqueOut = cfg_q.notchEnableSelect ? notchOut : lpNext;

    // ------------------------------------------------------------
    // loop state update
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            integ_q <= '0;
            tfilt_q <= '0;
            notchLp_q <= '0;
            posErr_q <= '0;
            prevRef_q <= '0;
            speedCmd_q <= '0;
            torqueCmd_q <= '0;
            alarm_q <= 1'b0;
        end else if (tick) begin
            integ_q <= integ_q + integStep;
            tfilt_q <= lpNext;
            notchLp_q <= notchLp_q + nDelta;
            posErr_q <= errNow;
            prevRef_q <= refExt;
            speedCmd_q <= speedRef[DATA_W-1:0];
            torqueCmd_q <= torqueOut[DATA_W-1:0];
            alarm_q <= overflowNow;
        end
    end
    assign speedCmd = speedCmd_q;
    assign torqueCmd = torqueCmd_q;
    assign positionErrorOverflowAlarm = alarm_q;

    // ------------------------------------------------------------
    // interrupt status: events set, read clears, set wins
    // ------------------------------------------------------------
    logic [slt_pkg::IRQ_W-1:0] irqEvt;
    assign irqEvt[slt_pkg::IRQ_OVERFLOW] = tick && overflowNow && !alarm_q;
    assign irqEvt[slt_pkg::IRQ_TUNE_DONE] = tuneApply;
    assign irqEvt[slt_pkg::IRQ_REJECT] = writeBad;
    wire stsRead = busRead && selSts;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) irqStatus_q <= '0;
        else irqStatus_q <= (stsRead ? '0 : irqStatus_q) | irqEvt;
    end
    assign irq = |(irqStatus_q & irqMask_q);

endmodule

/* File: slt_servo_core_assertions.sv */
// checker: concurrent assertions on the servo tuning core ports
`timescale 1ns/1ps
module slt_servo_core_assertions #(
    parameter int DATA_W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // apb slave side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pslverr,
    // loop outputs
    input wire logic signed [DATA_W-1:0] speedCmd,
    input wire logic positionErrorOverflowAlarm
);
    // --------------------------------------------------
    // access decode
    // --------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic wrAcc = psel && penable && pwrite;  // write in access phase
    // --------------------------------------------------
    // properties
    // --------------------------------------------------
    chk_unmapped_err: assert property (psel && penable && paddr > 8'h30 |-> pslverr)
        else $error("unmapped access not refused");
    chk_freq_range: assert property (wrAcc && paddr == slt_pkg::REG_NOTCH_FREQ
        |-> pslverr == (pwdata < 32'h0000_0032 || pwdata > 32'h0000_07D0))
        else $error("notch centre range check wrong");
    chk_speed_gain_range: assert property (wrAcc && paddr == slt_pkg::REG_SPEED_GAIN
        |-> pslverr == (pwdata < 32'h0000_0001 || pwdata > 32'h0000_07D0))
        else $error("speed gain range check wrong");
    chk_integral_range: assert property (wrAcc && paddr == slt_pkg::REG_SPEED_INTEGRAL
        |-> pslverr == (pwdata < 32'h0000_000F || pwdata > 32'h0000_C800))
        else $error("integral time range check wrong");
    chk_inertia_range: assert property (wrAcc && paddr == slt_pkg::REG_INERTIA_RATIO
        |-> pslverr == (pwdata > 32'h0000_2710))
        else $error("inertia ratio range check wrong");
    chk_level_range: assert property (wrAcc && paddr == slt_pkg::REG_OVERFLOW_LEVEL
        |-> pslverr == (pwdata < 32'h0000_0001 || pwdata > 32'h0000_7FFF))
        else $error("overflow level range check wrong");
    chk_ff_range: assert property (wrAcc && paddr == slt_pkg::REG_FF_WEIGHT
        |-> pslverr == (pwdata > 32'h0000_0064))
        else $error("feed-forward range check wrong");
    chk_alarm_hold: assert property ($changed(positionErrorOverflowAlarm)
        |=> $stable(positionErrorOverflowAlarm) [*8])
        else $error("alarm moved between loop ticks");
    chk_cmd_hold: assert property ($changed(speedCmd) |=> $stable(speedCmd) [*8])
        else $error("speed command moved between loop ticks");
endmodule

bind slt_servo_core slt_servo_core_assertions #(.DATA_W(DATA_W)) u_chk (.clk(clk),
    .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pslverr(pslverr), .speedCmd(speedCmd),
    .positionErrorOverflowAlarm(positionErrorOverflowAlarm));

/* File: slt_host_model.sv */
// host model: drives loop references and auto-tuning results into the core
`timescale 1ns/1ps
module slt_host_model #(
    parameter int DATA_W = 16
) (
    // clock
    input wire logic clk,
    // references to the core
    output logic signed [DATA_W-1:0] posRef,
    output logic signed [DATA_W-1:0] posFeedback,
    output logic signed [DATA_W-1:0] speedFeedback,
    output logic zeroClamp,
    // tuning result
    output logic tuneValid,
    output slt_pkg::slt_tune_s tuneGains
);
    // quiet references at time zero
    initial begin
        posRef = '0;
        posFeedback = '0;
        speedFeedback = '0;
        zeroClamp = 1'b0;
        tuneValid = 1'b0;
        tuneGains = '0;
    end
    // new references just after an edge; any offset trim stays manual here
    task automatic set_refs(input logic signed [DATA_W-1:0] r, f, input logic zc);
        @(posedge clk);
        posRef <= r;
        posFeedback <= f;
        speedFeedback <= f;
        zeroClamp <= zc;
    endtask
    // one-cycle tuning pulse; gains scrambled once the pulse is gone
    task automatic tune(input slt_pkg::slt_tune_s g);
        @(posedge clk);
        tuneValid <= 1'b1;
        tuneGains <= g;
        @(posedge clk);
        tuneValid <= 1'b0;
        tuneGains <= ~g;
    endtask
endmodule

/* File: servo_loop_tuning_filters_test.sv */
// testbench: register, range, tuning, alarm and zero clamp tests of the core
`timescale 1ns/1ps
module servo_loop_tuning_filters_test;
    // --------------------------------------------------
    // signals
    // --------------------------------------------------
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, er, tuneValid, zeroClamp, alarm, irq;
    logic signed [15:0] posRef, posFeedback, speedFeedback, speedCmd, torqueCmd;
    slt_pkg::slt_tune_s tuneGains;
    int n_fail = 0, n_checks = 0;
    // reset values, rejected values and accepted values per register (feed-forward 80)
    localparam logic [31:0] RSTV [9] = '{32'h64, 32'h0, 32'h7D0, 32'h28, 32'h7D0, 32'h64,
        32'h28, 32'h400, 32'h0};
    localparam logic [31:0] BADV [9] = '{32'h1_0000, 32'h2, 32'h31, 32'h0, 32'hE, 32'h2711,
        32'h7D1, 32'h0, 32'h65};
    localparam logic [31:0] GOODV [9] = '{32'hFFFF, 32'h1, 32'h32, 32'h7D0, 32'hC800, 32'h2710,
        32'h0, 32'h1, 32'h50};
    // 200 MHz clock
    always #2.5 clk = ~clk;
    // --------------------------------------------------
    // instances
    // --------------------------------------------------
    slt_servo_core u_slt_servo_core (.clk(clk), .arst_n(arst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .posRef(posRef), .posFeedback(posFeedback),
        .speedFeedback(speedFeedback), .zeroClamp(zeroClamp), .tuneValid(tuneValid),
        .tuneGains(tuneGains), .speedCmd(speedCmd), .torqueCmd(torqueCmd),
        .positionErrorOverflowAlarm(alarm), .irq(irq));
    slt_host_model u_slt_host_model (.clk(clk), .posRef(posRef), .posFeedback(posFeedback),
        .speedFeedback(speedFeedback), .zeroClamp(zeroClamp), .tuneValid(tuneValid),
        .tuneGains(tuneGains));
    // --------------------------------------------------
    // tasks
    // --------------------------------------------------
    // verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // compare one value
    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one apb transfer; read data and error taken at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int k = 0; k < 20; k++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
            if (k == 19) begin
                check("apb ready", 32'(pready), 32'h1);
                close_out();
            end
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // wait a bounded time for the alarm level
    task automatic wait_alarm(input logic lvl);
        for (int k = 0; k < 3 * slt_pkg::LOOP_CYCLES && alarm !== lvl; k++) @(posedge clk);
        check("overflow alarm", 32'(alarm), 32'(lvl));
        if (alarm !== lvl) close_out();
    endtask
    // --------------------------------------------------
    // main sequence
    // --------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, 8'(i * 4), 32'h0);
            check("reset value", rd, RSTV[i]);
        end
        check("torque reset", 32'(torqueCmd), 32'h0);
        $display("test reset values done");
        for (int i = 0; i < 9; i++) begin
            apb(1'b1, 8'(i * 4), BADV[i]);
            check("reject flag", 32'(er), 32'h1);
            apb(1'b0, 8'(i * 4), 32'h0);
            check("kept value", rd, RSTV[i]);
            apb(1'b1, 8'(i * 4), GOODV[i]);
            check("accept flag", 32'(er), 32'h0);
            apb(1'b0, 8'(i * 4), 32'h0);
            check("new value", rd, GOODV[i]);
        end
        apb(1'b0, 8'h34, 32'h0);
        check("unmapped error", 32'(er), 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b0, slt_pkg::REG_IRQ_STATUS, 32'h0);
        check("reject status", rd, 32'h4);
        check("masked irq", 32'(irq), 32'h0);
        $display("test ranges done");
        apb(1'b1, slt_pkg::REG_IRQ_MASK, 32'h7);
        u_slt_host_model.tune('{16'd100, 16'd300, 16'd250, 16'd60});
        @(posedge clk);
        check("tuning irq", 32'(irq), 32'h1);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(12 + i * 4), 32'h0);
            check("tuned value", rd, 32'(tuneGains[63 - i * 16 -: 16] ^ 16'hFFFF));
        end
        // software strobe applies whatever the host now offers: the inverted gains
        apb(1'b1, slt_pkg::REG_TUNE_CTRL, 32'h0000_0001);
        apb(1'b0, slt_pkg::REG_SPEED_GAIN, 32'h0);
        check("tune by write", rd, 32'h0000_FF9B);
        apb(1'b0, slt_pkg::REG_IRQ_STATUS, 32'h0);
        check("tune status", rd, 32'h2);
        @(posedge clk);
        check("cleared irq", 32'(irq), 32'h0);
        $display("test tuning done");
        u_slt_host_model.set_refs(16'sd300, 16'sd0, 1'b0);
        wait_alarm(1'b1);
        apb(1'b0, slt_pkg::REG_IRQ_STATUS, 32'h0);
        check("overflow status", rd, 32'h1);
        u_slt_host_model.set_refs(16'sd256, 16'sd0, 1'b0);
        wait_alarm(1'b0);
        $display("test overflow done");
        apb(1'b1, slt_pkg::REG_POSITION_GAIN, 32'h5);
        u_slt_host_model.set_refs(16'sd0, 16'sd3, 1'b1);
        repeat (2 * slt_pkg::LOOP_CYCLES + 2) @(posedge clk);
        check("clamp command", 32'(speedCmd), 32'(-16'sd15));
        $display("test zero clamp done");
        close_out();
    end
endmodule
